/* File: dv/host_model.sv */
// Host controller model that programs the register bank over Avalon-MM.
// Assumes a slave that answers by lowering waitrequest; one clock.
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic        clock,
   output logic      [7:0]  address,
   output logic             read,
   output logic             write,
   output logic      [3:0]  byteenable,
   output logic      [31:0] writedata,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   import modctl_pkg::*;
   initial
   begin
      address    = 8'h00;
      read       = 1'b0;
      write      = 1'b0;
      byteenable = 4'h3;
      writedata  = 32'h0000_0000;
   end
   // One transfer; request held until the edge that sees waitrequest low
   task automatic xfer(input logic [5:0] idx, input logic wr, input logic [15:0] d,
                       output logic [15:0] q);
      logic [15:0] w;
      w = d;
      if (wr && idx == IDX_MOD_CTL)
         w = (d & 16'h81FF) | 16'h1000;
      @(posedge clock);
      address   <= {idx, 2'b00};
      read      <= !wr;
      write     <= wr;
      writedata <= {16'h0000, w};
      @(posedge clock);
      while (waitrequest !== 1'b0)
         @(posedge clock);
      // Read data taken at the edge that sees waitrequest low
      q = readdata[15:0];
      read      <= 1'b0;
      write     <= 1'b0;
      // Released data lines never keep the old value
      writedata <= ~{16'h0000, w};
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the modulation and output control registers.
// Assumes the host model on the register bus and a 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import modctl_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [3:0]  byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        freq_req = 1'b0;
   logic        reference_multiplier_en  = 1'b0;
   logic        lock     = 1'b0;
   logic        prof_sw  = 1'b0;
   logic [2:0]  symbol   = 3'h0;
   logic        muted, settling, tx_t, rx_t, term, fs_pol, clk_edge, active;
   mod_mode_t   mode;
   logic [15:0] dev;
   logic [15:0] q, v, e;
   logic        sym_run  = 1'b1;
   logic [2:0]  sym_fix  = 3'h0;
   logic [15:0] devs [0:7];
   int          fails    = 0;
   int          n_tests  = 0;
   int          cycles   = 0;
   int          n;

   always #10 clock = ~clock;

   modulation_and_output_control_regs i_dut (
      .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .freq_change_req(freq_req),
      .reference_multiplier_enable(reference_multiplier_en), .lock_detect(lock),
      .profile_switch(prof_sw), .shift_symbol(symbol), .outputs_muted(muted),
      .settling(settling), .tx_output_drive_type(tx_t), .rx_output_drive_type(rx_t),
      .ref_input_termination_enable(term), .frame_sync_polarity(fs_pol),
      .serial_clock_edge_select(clk_edge), .modulation_mode(mode),
      .modulation_active(active), .deviation_out(dev));

   host_model i_host (
      .clock(clock), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      i_host.xfer(idx, 1'b1, d, q);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
      i_host.xfer(idx, 1'b0, 16'h0000, q);
      check("readback", q, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask

   // Length of the settle wait after one restart pulse
   task automatic settle_len();
      @(posedge clock);
      freq_req <= 1'b1;
      @(posedge clock);
      freq_req <= 1'b0;
      n = 0;
      @(posedge clock);
      while (settling === 1'b1 && n < 3000)
      begin
         n++;
         @(posedge clock);
      end
   endtask

   // Two, four or eight levels use one, two or three symbol bits
   function automatic logic [2:0] pin_entry(input logic [1:0] lv, input logic [2:0] s);
      return s & 3'((4'h1 << lv) - 4'h1);
   endfunction

   function automatic logic [15:0] fix_res(input logic [15:0] x);
      return (x & 16'h81FF) | 16'h1000;
   endfunction

   // Random symbol pins keep the pin path busy
   always @(posedge clock)
      symbol <= sym_run ? 3'($urandom) : sym_fix;

   // Hang guard, far above the expected run
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fails++;
         test_done();
      end
   end

   initial
   begin
      void'($urandom(32'h90d5c9b0));
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      cyc(1);
      check("tx_type", 16'(tx_t), 16'h0001);
      check("rx_type", 16'(rx_t), 16'h0001);
      rd_chk(IDX_FAST_DEV, 16'h0000);
      rd_chk(IDX_MOD_CTL, 16'h1000);
      rd_chk(IDX_SETTLE_CTL, 16'h0647);
      rd_chk(IDX_DEV_P1_FIRST, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         v = 16'($urandom);
         v[1:0] = 2'(i);
         wr(IDX_MOD_CTL, v);
         e = fix_res(v);
         rd_chk(IDX_MOD_CTL, e);
         check("term", 16'(term), 16'(e[15]));
         check("fs_pol", 16'(fs_pol), 16'(e[8]));
         check("clk_edge", 16'(clk_edge), 16'(e[7]));
         check("mode", 16'(mode), 16'(e[1:0]));
         v = 16'($urandom) | 16'h0008;
         wr(IDX_SETTLE_CTL, v);
         rd_chk(IDX_SETTLE_CTL, v);
         check("tx_type", 16'(tx_t), 16'(v[1]));
         check("rx_type", 16'(rx_t), 16'(v[0]));
         v = 16'($urandom);
         wr(IDX_FAST_DEV, v);
         rd_chk(IDX_FAST_DEV, v);
      end
      // Unmapped place: write dropped, reads zero
      wr(6'h3F, 16'hFFFF);
      rd_chk(6'h3F, 16'h0000);
      rd_chk(IDX_MOD_CTL, e);
      wr(IDX_SETTLE_CTL, 16'h002F);
      settle_len();
      check("settle", 16'(n), 16'h0005);
      cyc(10);
      check("muted", 16'(muted), 16'h0001);
      lock <= 1'b1;
      cyc(8);
      check("muted", 16'(muted), 16'h0000);
      lock <= 1'b0;
      cyc(20);
      check("muted", 16'(muted), 16'h0000);
      prof_sw <= 1'b1;
      cyc(12);
      check("muted", 16'(muted), 16'h0001);
      lock <= 1'b1;
      cyc(20);
      check("muted", 16'(muted), 16'h0000);
      wr(IDX_SETTLE_CTL, 16'h000F);
      settle_len();
      check("settle", 16'(n), 16'h0001);
      reference_multiplier_en <= 1'b1;
      settle_len();
      check("multiplier_settle_count", 16'(n), 16'h03E8);
      reference_multiplier_en <= 1'b0;
      wr(IDX_PROFILE_EN, 16'h0003);
      for (int s = 0; s < 8; s++)
      begin
         v = 16'($urandom) | 16'h0001;
         devs[s] = v;
         wr(IDX_DEV_P2_FIRST + 6'(s), v);
         wr(IDX_MOD_CTL, 16'h0021 | 16'(s << 2));
         cyc(4);
         check("dev", dev, v);
         wr(IDX_MOD_CTL, 16'h0001 | 16'(s << 2));
         cyc(4);
         check("dev_off", dev, 16'h0000);
         check("active", 16'(active), 16'h0000);
      end
      // Pin-driven mode with the symbol pins held still
      sym_run <= 1'b0;
      for (int l = 1; l < 4; l++)
      begin
         sym_fix <= 3'($urandom);
         wr(IDX_MOD_CTL, 16'(l << 5));
         cyc(6);
         check("pin_dev", dev, devs[pin_entry(2'(l), sym_fix)]);
      end
      sym_run <= 1'b1;
      wr(IDX_FAST_DEV, 16'hA5C3);
      wr(IDX_MOD_CTL, 16'h0003);
      cyc(4);
      check("fast", dev, 16'hA5C3);
      check("active", 16'(active), 16'h0001);
      wr(IDX_PROFILE_EN, 16'h0000);
      cyc(4);
      check("fast_off", dev, 16'h0000);
      check("active", 16'(active), 16'h0000);
      test_done();
   end
endmodule
`default_nettype wire

/* File: rtl/modctl_pkg.sv */
// Constants for the modulation and output control register bank.
// Assumes a 50 MHz reference clock and a 32-bit Avalon-MM register bus.
package modctl_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_DEV_P1_FIRST  = 6'h09;
   localparam logic [5:0] IDX_DEV_P1_LAST   = 6'h10;
   localparam logic [5:0] IDX_DEV_P2_FIRST  = 6'h19;
   localparam logic [5:0] IDX_DEV_P2_LAST   = 6'h20;
   localparam logic [5:0] IDX_FAST_DEV      = 6'h21;
   localparam logic [5:0] IDX_MOD_CTL       = 6'h22;
   localparam logic [5:0] IDX_SETTLE_CTL    = 6'h23;
   localparam logic [5:0] IDX_PROFILE_EN    = 6'h30;
   localparam logic [5:0] IDX_STATUS        = 6'h31;
   // Reset values
   localparam logic [15:0] RST_FAST_DEV     = 16'h0000;
   localparam logic [15:0] RST_MOD_CTL      = 16'h1000;
   localparam logic [15:0] RST_SETTLE_CTL   = 16'h0647;
   localparam logic [15:0] RST_DEV_ENTRY    = 16'h0000;
   localparam logic [1:0]  RST_PROFILE_EN   = 2'h0;
   // Field positions, settle and output control
   localparam int SC_COUNT_MSB   = 13;
   localparam int SC_COUNT_LSB   = 3;
   localparam int SC_MUTE_BIT    = 2;
   localparam int SC_TX_TYPE_BIT = 1;
   localparam int SC_RX_TYPE_BIT = 0;
   // Field positions, modulation control
   localparam int MC_TERM_BIT    = 15;
   localparam int MC_FS_POL_BIT  = 8;
   localparam int MC_CLK_POL_BIT = 7;
   localparam int MC_LEVEL_MSB   = 6;
   localparam int MC_LEVEL_LSB   = 5;
   localparam int MC_DEVSEL_MSB  = 4;
   localparam int MC_DEVSEL_LSB  = 2;
   localparam int MC_MODE_A_BIT  = 1;
   localparam int MC_MODE_B_BIT  = 0;
   // Modulation modes, first code bit is the upper one
   typedef enum logic [1:0] {
      MODE_PIN   = 2'h0,
      MODE_REG   = 2'h1,
      MODE_AUDIO = 2'h2,
      MODE_FAST  = 2'h3
   } mod_mode_t;
   // Switching sequence states
   typedef enum logic [1:0] {
      ST_SETTLE = 2'h0,
      ST_LOCK   = 2'h1,
      ST_RUN    = 2'h3
   } seq_state_t;
   // Multiplier settling time
   localparam int CLK_PERIOD_NS  = 20;
   localparam int REFERENCE_MULTIPLIER_SETTLE_NS = 20000;
   localparam logic [10:0] REFERENCE_MULTIPLIER_SETTLE_CYCLES =
      11'((REFERENCE_MULTIPLIER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

/* File: rtl/modulation_and_output_control_regs.sv */
// Modulation and output control registers with the switching sequencer.
// Assumes clock is the reference input clock and an Avalon-MM master.
// Function
// - Enabled multiplier gets twenty microseconds settling
// - Settle count bits 13:3, cycles 1..2047
// - Settle wait always part of switching
// - Mute until lock after init, change, switch
// - Later lock loss never re-mutes outputs
// - Bit 1 sets transmit drive, push-pull default
// - Bit 0 sets receive drive, push-pull default
// - Bit 15 enables reference input termination
// - Bit 8 sets frame sync polarity
// - Bit 7 selects serial clock strobe edge
// - Bits 6:5 select shift level count
// - Level zero disables pin and register modes
// - Bits 4:2 select register-mode deviation entry
// - Bits 1:0 form mode, bit 1 first
// - Fast deviation word, sixteen bits, resets zero
// - Profile enable turns modulation on
// - Eight deviation entries per profile, reset zero
`timescale 1ns/1ns
`default_nettype none
module modulation_and_output_control_regs (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        freq_change_req,
   input  wire logic        reference_multiplier_enable,
   input  wire logic        lock_detect,
   input  wire logic        profile_switch,
   input  wire logic [2:0]  shift_symbol,
   output logic             outputs_muted,
   output logic             settling,
   output logic             tx_output_drive_type,
   output logic             rx_output_drive_type,
   output logic             ref_input_termination_enable,
   output logic             frame_sync_polarity,
   output logic             serial_clock_edge_select,
   output modctl_pkg::mod_mode_t modulation_mode,
   output logic             modulation_active,
   output logic      [15:0] deviation_out
);
   import modctl_pkg::*;

   typedef struct packed {
      logic [15:0]       fast_deviation_word;
      logic [15:0]       modulation_control;
      logic [15:0]       settle_and_output_control;
      logic [1:0]        profile_modulation_enable;
      logic [15:0][15:0] deviation_entry;
      seq_state_t        state;
      logic [10:0]       count;
      logic              released;
      logic              muted;
      logic              ack;
      logic [31:0]       rdata;
      logic [15:0]       dev_out;
      logic [1:0]        lock_sync;
      logic [1:0]        prof_sync;
      logic              prof_last;
      logic [2:0]        sym_meta;
      logic [2:0]        sym_sync;
   } state_t;

   state_t cur_reg;
   state_t cur_next;

   // Deviation entry slot for an index: {hit, profile, entry}
   function automatic logic [4:0] dev_slot(input logic [5:0] idx);
      logic [5:0] off;
      off = 6'h00;
      dev_slot = 5'h00;
      if (idx >= IDX_DEV_P1_FIRST && idx <= IDX_DEV_P1_LAST)
      begin
         off = idx - IDX_DEV_P1_FIRST;
         dev_slot = {2'b10, off[2:0]};
      end
      else if (idx >= IDX_DEV_P2_FIRST && idx <= IDX_DEV_P2_LAST)
      begin
         off = idx - IDX_DEV_P2_FIRST;
         dev_slot = {2'b11, off[2:0]};
      end
   endfunction

   // Byte-enable merge of a sixteen-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   logic [5:0]  idx;
   logic [4:0]  slot;
   logic        access;
   logic [10:0] cfg_wait;
   logic [10:0] wait_target;
   logic        restart;
   logic        prof_sel;
   logic [1:0]  level;
   logic [2:0]  sym_mask;
   logic [3:0]  entry_sel;
   logic        mod_on;

   assign idx    = address[7:2];
   assign slot   = dev_slot(idx);
   assign access = (read || write) && !cur_reg.ack;
   // Waitrequest drops one cycle after the request arrives
   assign waitrequest = (read || write) && !cur_reg.ack;

   always_comb
   begin
      cur_next = cur_reg;
      cur_next.ack = access;
      // Zero count is illegal; treat it as the shortest wait
      cfg_wait = cur_reg.settle_and_output_control[SC_COUNT_MSB:SC_COUNT_LSB];
      if (cfg_wait == 11'h000)
      begin
         cfg_wait = 11'h001;
      end
      wait_target = cfg_wait;
      if (reference_multiplier_enable && wait_target < REFERENCE_MULTIPLIER_SETTLE_CYCLES)
      begin
         wait_target = REFERENCE_MULTIPLIER_SETTLE_CYCLES;
      end
      prof_sel = cur_reg.prof_sync[1];
      restart  = freq_change_req || (prof_sel != cur_reg.prof_last);
      level    = cur_reg.modulation_control[MC_LEVEL_MSB:MC_LEVEL_LSB];

      // Synchronisers for pin inputs
      cur_next.lock_sync = {cur_reg.lock_sync[0], lock_detect};
      cur_next.prof_sync = {cur_reg.prof_sync[0], profile_switch};
      cur_next.sym_meta  = shift_symbol;
      cur_next.sym_sync  = cur_reg.sym_meta;
      cur_next.prof_last = prof_sel;

      // Register writes take effect on the acknowledging edge
      if (write && cur_reg.ack)
      begin
         if (slot[4])
         begin
            cur_next.deviation_entry[slot[3:0]] =
               merge16(cur_reg.deviation_entry[slot[3:0]], writedata, byteenable);
         end
         unique case (idx)
            IDX_FAST_DEV: cur_next.fast_deviation_word =
               merge16(cur_reg.fast_deviation_word, writedata, byteenable);
            IDX_MOD_CTL: cur_next.modulation_control =
               merge16(cur_reg.modulation_control, writedata, byteenable);
            IDX_SETTLE_CTL: cur_next.settle_and_output_control =
               merge16(cur_reg.settle_and_output_control, writedata, byteenable);
            IDX_PROFILE_EN: if (byteenable[0])
            begin
               cur_next.profile_modulation_enable = writedata[1:0];
            end
            default: ;
         endcase
      end

      // Read data; unmapped indices read zero
      if (read && access)
      begin
         cur_next.rdata = 32'h0000_0000;
         if (slot[4])
         begin
            cur_next.rdata[15:0] = cur_reg.deviation_entry[slot[3:0]];
         end
         unique case (idx)
            IDX_FAST_DEV:   cur_next.rdata[15:0] = cur_reg.fast_deviation_word;
            IDX_MOD_CTL:    cur_next.rdata[15:0] = cur_reg.modulation_control;
            IDX_SETTLE_CTL: cur_next.rdata[15:0] = cur_reg.settle_and_output_control;
            IDX_PROFILE_EN: cur_next.rdata[1:0]  = cur_reg.profile_modulation_enable;
            IDX_STATUS: cur_next.rdata[4:0] = {cur_reg.state, cur_reg.lock_sync[1],
                                               cur_reg.released, cur_reg.muted};
            default: ;
         endcase
      end

      // Switching sequence: settle, wait for lock, run
      unique case (cur_reg.state)
         ST_SETTLE:
         begin
            cur_next.count = cur_reg.count + 11'h001;
            if (cur_next.count >= wait_target)
            begin
               cur_next.state = ST_LOCK;
               cur_next.count = 11'h000;
            end
         end
         ST_LOCK:
         begin
            if (cur_reg.lock_sync[1])
            begin
               cur_next.state    = ST_RUN;
               cur_next.released = 1'b1;
            end
         end
         ST_RUN: ; // Lock loss keeps the outputs live
         default:
         begin
            cur_next.state = ST_SETTLE;
         end
      endcase
      if (restart)
      begin
         cur_next.state    = ST_SETTLE;
         cur_next.count    = 11'h000;
         cur_next.released = 1'b0;
      end
      cur_next.muted = cur_next.settle_and_output_control[SC_MUTE_BIT]
                       && !cur_next.released;

      // Deviation selection per mode
      sym_mask  = (level == 2'h1) ? 3'h1 : (level == 2'h2) ? 3'h3 : 3'h7;
      entry_sel = {prof_sel, 3'h0};
      mod_on    = cur_reg.profile_modulation_enable[prof_sel];
      cur_next.dev_out = 16'h0000;
      unique case (mod_mode_t'({cur_reg.modulation_control[MC_MODE_A_BIT],
                                cur_reg.modulation_control[MC_MODE_B_BIT]}))
         MODE_PIN:
         begin
            entry_sel = {prof_sel, cur_reg.sym_sync & sym_mask};
            mod_on    = mod_on && level != 2'h0;
            cur_next.dev_out = cur_reg.deviation_entry[entry_sel];
         end
         MODE_REG:
         begin
            entry_sel = {prof_sel,
                         cur_reg.modulation_control[MC_DEVSEL_MSB:MC_DEVSEL_LSB]};
            mod_on    = mod_on && level != 2'h0;
            cur_next.dev_out = cur_reg.deviation_entry[entry_sel];
         end
         MODE_AUDIO: ; // Serial samples drive deviation elsewhere
         MODE_FAST: cur_next.dev_out = cur_reg.fast_deviation_word;
      endcase
      if (!mod_on)
      begin
         cur_next.dev_out = 16'h0000;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_reg <= '{fast_deviation_word:       RST_FAST_DEV,
                      modulation_control:        RST_MOD_CTL,
                      settle_and_output_control: RST_SETTLE_CTL,
                      profile_modulation_enable: RST_PROFILE_EN,
                      deviation_entry:           {16{RST_DEV_ENTRY}},
                      state:                     ST_SETTLE,
                      count:                     11'h000,
                      released:                  1'b0,
                      muted:                     1'b1,
                      ack:                       1'b0,
                      rdata:                     32'h0000_0000,
                      dev_out:                   16'h0000,
                      lock_sync:                 2'h0,
                      prof_sync:                 2'h0,
                      prof_last:                 1'b0,
                      sym_meta:                  3'h0,
                      sym_sync:                  3'h0};
      end
      else
      begin
         cur_reg <= cur_next;
      end
   end

   assign readdata      = cur_reg.rdata;
   assign outputs_muted = cur_reg.muted;
   assign settling      = (cur_reg.state == ST_SETTLE);
   assign deviation_out = cur_reg.dev_out;
   assign tx_output_drive_type =
      cur_reg.settle_and_output_control[SC_TX_TYPE_BIT];
   assign rx_output_drive_type =
      cur_reg.settle_and_output_control[SC_RX_TYPE_BIT];
   assign ref_input_termination_enable = cur_reg.modulation_control[MC_TERM_BIT];
   assign frame_sync_polarity      = cur_reg.modulation_control[MC_FS_POL_BIT];
   assign serial_clock_edge_select = cur_reg.modulation_control[MC_CLK_POL_BIT];
   assign modulation_mode = mod_mode_t'({cur_reg.modulation_control[MC_MODE_A_BIT],
                                         cur_reg.modulation_control[MC_MODE_B_BIT]});
   assign modulation_active = (cur_reg.dev_out != 16'h0000) || (mod_on &&
                              modulation_mode inside {MODE_AUDIO, MODE_FAST});

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_restart;
      restart ##1 (cur_reg.state == ST_SETTLE);
   endsequence

   chk_settle_min_reference_multiplier: assert property (
      (cur_reg.state == ST_SETTLE && cur_next.state == ST_LOCK && !restart
       && reference_multiplier_enable) |-> (cur_reg.count + 11'h001 >= REFERENCE_MULTIPLIER_SETTLE_CYCLES))
      else $error("multiplier settle too short");
   chk_settle_count_len: assert property (
      (cur_reg.state == ST_SETTLE && cur_next.state == ST_LOCK && !restart)
      |-> (cur_reg.count + 11'h001 >= cfg_wait))
      else $error("settle count not honoured");
   chk_restart_settles: assert property (
      s_restart |-> !cur_reg.released)
      else $error("restart skipped settling");
   chk_mute_until_lock: assert property (
      (cur_reg.state != ST_RUN && cur_reg.settle_and_output_control[SC_MUTE_BIT])
      |-> cur_reg.muted)
      else $error("outputs live before lock");
   chk_no_remute: assert property (
      (cur_reg.state == ST_RUN && !restart && $stable(cur_reg.settle_and_output_control))
      ##1 !cur_reg.lock_sync[1] |-> $stable(cur_reg.muted))
      else $error("lock loss changed mute");
   chk_level_zero_off: assert property (
      (level == 2'h0 && modulation_mode inside {MODE_PIN, MODE_REG})
      ##1 $stable(cur_reg.modulation_control) |-> (deviation_out == 16'h0000))
      else $error("modulation with level zero");
   chk_fast_word_out: assert property (
      (modulation_mode == MODE_FAST && mod_on) |=> (deviation_out == $past(cur_reg.fast_deviation_word)))
      else $error("fast word not applied");
   chk_write_holds: assert property (
      !(write && !waitrequest) |=> $stable(cur_reg.modulation_control)
                             && $stable(cur_reg.fast_deviation_word))
      else $error("register changed without write");
   chk_bus_answer: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held too long");
endmodule
`default_nettype wire
